// ===== logic/sspc_socket_ctrl.sv
// Purpose: Per-socket status, power, output enable and irq routing logic.
// Assumes: Index/data access strobes are one-cycle pulses on mclk_i.
// Notes:   Outputs are registered; the card reset pin has its own output enable beside the socket one.
`timescale 1ns/1ps
module sspc_socket_ctrl #(
  parameter int unsigned SOCKET_ID = 0
) (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  // Index/data register access
  input  wire logic        idx_wr_i,
  input  wire logic        data_wr_i,
  input  wire logic        data_rd_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o,
  output logic             rd_valid_o,
  // Card pins
  input  wire logic        card_ready_irq_pin_i,
  input  wire logic        write_protect_wide_io_pin_i,
  input  wire logic        card_detect_first_n_i,
  input  wire logic        card_detect_second_n_i,
  input  wire logic        battery_status_ring_pin_i,
  input  wire logic        battery_warn_speaker_pin_i,
  // Control bits held elsewhere in the adapter
  input  wire logic        vcc_3v3_sel_i,
  input  wire logic        auto_off_disable_i,
  input  wire logic        vcc_write_lock_i,
  input  wire logic        ata_mode_i,
  input  wire logic        irq15_ring_out_select_i,
  input  wire logic        irq14_clk_in_sel_i,
  input  wire logic        mgmt_irq_req_i,
  input  wire logic [3:0]  mgmt_irq_level_i,
  // Socket power and outputs
  output logic             vcc_3v3_n_o,
  output logic             vcc_5v_n_o,
  output logic             prog_voltage_select_o,
  output logic             vpp_follow_vcc_o,
  output logic             sock_out_en_o,
  output logic             card_reset_o,
  output logic             card_reset_oe_o,
  output logic             io_interface_mode_o,
  output logic [15:0]      irq_o
);

  // Elaboration check: only two sockets exist
  if (SOCKET_ID > 1) begin : g_bad_socket
    $error("SOCKET_ID must be 0 or 1");
  end

  logic [7:0]  index_q;
  logic [7:0]  power_q;
  logic [7:0]  igc_q;
  logic [5:0]  pins_s;
  logic [5:0]  pins_raw;
  logic        present;
  logic        present_q;
  logic        power_act;
  logic        sel_hit;
  logic        wr_power;
  logic        wr_igc;
  logic        removal;
  logic [7:0]  status_byte;
  logic [7:0]  rdata_d;
  logic        rd_status_q;
  logic [15:0] irq_d;
  logic        card_irq;
  logic        ring_active;
  logic [1:0]  vpp_code;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // Routing decode: one-hot line for valid codes, none otherwise
  function automatic logic [15:0] route(input logic [3:0] code);
    logic [15:0] onehot;
    onehot = 16'h0001 << code;
    return onehot & sspc_pkg::IRQ_VALID_MASK;
  endfunction

  assign pins_raw = {card_detect_second_n_i, card_detect_first_n_i,
                     battery_warn_speaker_pin_i, battery_status_ring_pin_i,
                     write_protect_wide_io_pin_i, card_ready_irq_pin_i};

  sspc_sync #(
    .W       (sspc_pkg::PIN_W),
    .RST_VAL (sspc_pkg::PIN_RST)
  ) u_pin_sync (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (pins_raw),
    .sync_o    (pins_s)
  );

  // Card fully inserted when both detect pins are low
  assign present = ~pins_s[sspc_pkg::PIN_CD1_N] &
                   ~pins_s[sspc_pkg::PIN_CD2_N];

  assign sel_hit  = (index_q[sspc_pkg::IDX_SOCKET_BIT] == SOCKET_ID[0]) &
                    ~index_q[7];
  assign wr_power = data_wr_i & sel_hit &
                    (index_q[5:0] == sspc_pkg::REG_POWER);
  assign wr_igc   = data_wr_i & sel_hit &
                    (index_q[5:0] == sspc_pkg::REG_IRQ_GEN);

  // Index register; reserved top bit held at zero
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      index_q <= sspc_pkg::IDX_RST;
    end else if (idx_wr_i) begin
      index_q <= wdata_i & sspc_pkg::IDX_WR_MASK;
    end
  end

  // Previous insertion state for removal detection
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      present_q <= 1'b0;
    end else begin
      present_q <= present;
    end
  end

  assign removal = present_q & ~present;

  // power control register, cleared by reset
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      power_q <= sspc_pkg::PWR_RST;
    end else begin
      if (wr_power) begin
        power_q[7:5] <= wdata_i[7:5];
        power_q[3:0] <= wdata_i[3:0];
        if (!vcc_write_lock_i) begin
          power_q[sspc_pkg::PWR_VCC] <= wdata_i[sspc_pkg::PWR_VCC];
        end
      end
      if (removal && !auto_off_disable_i) begin
        power_q[sspc_pkg::PWR_VCC] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      igc_q <= sspc_pkg::IGC_RST;
    end else if (wr_igc) begin
      igc_q <= wdata_i;
    end
  end

  assign power_act = ~sys_rst_i & power_q[sspc_pkg::PWR_VCC] &
                     (~power_q[sspc_pkg::PWR_AUTO] | present);
  assign vpp_code  = power_q[sspc_pkg::PWR_VPP_LO +: 2];

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !power_act) begin
      vcc_3v3_n_o           <= 1'b1;
      vcc_5v_n_o            <= 1'b1;
      prog_voltage_select_o <= 1'b0;
      vpp_follow_vcc_o      <= 1'b0;
    end else begin
      vcc_3v3_n_o           <= ~vcc_3v3_sel_i;
      vcc_5v_n_o            <= vcc_3v3_sel_i;
      prog_voltage_select_o <= (vpp_code == sspc_pkg::VPP_PROG_12V);
      vpp_follow_vcc_o      <= (vpp_code == sspc_pkg::VPP_FOLLOW_VCC);
    end
  end

  // socket output enables, card reset level
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sock_out_en_o   <= 1'b0;
      card_reset_oe_o <= 1'b0;
      card_reset_o    <= 1'b0;
    end else begin
      sock_out_en_o   <= present & power_q[sspc_pkg::PWR_CARD_EN];
      card_reset_oe_o <= present & power_q[sspc_pkg::PWR_CARD_EN];
      card_reset_o    <= ~igc_q[sspc_pkg::IGC_RESET_OFF] ^ ata_mode_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      io_interface_mode_o <= 1'b0;
    end else begin
      io_interface_mode_o <= igc_q[sspc_pkg::IGC_IO_MODE];
    end
  end

  always_comb begin
    status_byte                      = 8'h00;
    status_byte[sspc_pkg::ST_TOP]    = 1'b1;
    status_byte[sspc_pkg::ST_PWR_ON] = power_act;
    status_byte[5]                   = pins_s[sspc_pkg::PIN_READY];
    status_byte[4]                   = pins_s[sspc_pkg::PIN_WP];
    status_byte[3]                   = ~pins_s[sspc_pkg::PIN_CD2_N];
    status_byte[2]                   = ~pins_s[sspc_pkg::PIN_CD1_N];
    status_byte[0]                   = pins_s[sspc_pkg::PIN_BVD1];
    // warning pin masked in I/O mode
    status_byte[1] = pins_s[sspc_pkg::PIN_BVD2] &
                     ~igc_q[sspc_pkg::IGC_IO_MODE];
  end

  // Read data multiplexer for the data port
  always_comb begin
    rdata_d = sspc_pkg::RD_NONE;
    if (sel_hit) begin
      case (index_q[5:0])
        sspc_pkg::REG_STATUS:  rdata_d = status_byte;
        sspc_pkg::REG_POWER:   rdata_d = power_q;
        sspc_pkg::REG_IRQ_GEN: rdata_d = igc_q;
        default:               rdata_d = sspc_pkg::RD_NONE;
      endcase
    end
  end

  // Registered read return, one cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rdata_o     <= 8'h00;
      rd_valid_o  <= 1'b0;
      rd_status_q <= 1'b0;
    end else begin
      rd_valid_o  <= data_rd_i;
      rd_status_q <= data_rd_i & sel_hit &
                     (index_q[5:0] == sspc_pkg::REG_STATUS);
      if (data_rd_i) begin
        rdata_o <= rdata_d;
      end
    end
  end

  // Card interrupt: active-low request pin in I/O mode only
  assign card_irq    = igc_q[sspc_pkg::IGC_IO_MODE] &
                       ~pins_s[sspc_pkg::PIN_READY];
  // ring indicate from the status pin
  assign ring_active = igc_q[sspc_pkg::IGC_IO_MODE] &
                       igc_q[sspc_pkg::IGC_RING_EN] &
                       irq15_ring_out_select_i &
                       ~pins_s[sspc_pkg::PIN_BVD1];

  always_comb begin
    irq_d = 16'h0000;
    if (card_irq) begin
      irq_d = irq_d | route(igc_q[sspc_pkg::IGC_LEVEL_LO +: 4]);
    end
    if (mgmt_irq_req_i && !igc_q[sspc_pkg::IGC_MGMT_SEL]) begin
      irq_d = irq_d | route(mgmt_irq_level_i);
    end
    // alternate uses of lines 14 and 15
    if (irq14_clk_in_sel_i) begin
      irq_d[sspc_pkg::IRQ_CLK_ALT] = 1'b0;
    end
    if (ring_active) begin
      irq_d[sspc_pkg::IRQ_RING_ALT] = 1'b1;
    end
  end

  // Registered interrupt lines
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_o <= 16'h0000;
    end else begin
      irq_o <= irq_d;
    end
  end

  // Assertions
  AST_STATUS_TOP: assert property (
    rd_status_q |-> rdata_o[sspc_pkg::ST_TOP])
    else $error("status top bit not one");
  AST_STATUS_DETECT: assert property (
    rd_status_q |-> rdata_o[3:2] ==
      ~$past({pins_s[sspc_pkg::PIN_CD2_N], pins_s[sspc_pkg::PIN_CD1_N]}))
    else $error("detect bits not inverted pins");
  AST_POWER_ON_BIT: assert property (
    rd_status_q |-> rdata_o[sspc_pkg::ST_PWR_ON] == $past(power_act))
    else $error("power-on status wrong");
  AST_SUPPLY_OFF: assert property (
    !power_act |=> vcc_3v3_n_o && vcc_5v_n_o &&
                   !prog_voltage_select_o && !vpp_follow_vcc_o)
    else $error("supply active while power off");
  AST_VPP_12V: assert property (
    power_act && vpp_code == sspc_pkg::VPP_PROG_12V
      |=> prog_voltage_select_o && !vpp_follow_vcc_o)
    else $error("programming decode wrong");
  AST_AUTO_OFF: assert property (
    removal && !auto_off_disable_i |=> !power_q[sspc_pkg::PWR_VCC])
    else $error("supply bit kept after removal");
  AST_WRITE_LOCK: assert property (
    wr_power && vcc_write_lock_i && !removal
      |=> $stable(power_q[sspc_pkg::PWR_VCC]))
    else $error("locked supply bit changed");

  AST_AUTO_GATE: assert property (
    power_q[sspc_pkg::PWR_AUTO] && !present |=> vcc_3v3_n_o && vcc_5v_n_o)
    else $error("auto power active without card");

  AST_OUT_EN: assert property (
    sock_out_en_o |-> $past(present && power_q[sspc_pkg::PWR_CARD_EN]))
    else $error("outputs enabled without cause");

  AST_RESET_FLOAT: assert property (
    !power_q[sspc_pkg::PWR_CARD_EN] |=> !card_reset_oe_o)
    else $error("reset driven with card disabled");

  AST_RESET_LEVEL: assert property (
    !igc_q[sspc_pkg::IGC_RESET_OFF] && !ata_mode_i |=> card_reset_o)
    else $error("card reset not asserted");

  AST_IRQ_ROUTE: assert property (
    card_irq && igc_q[3:0] == 4'h3 |=> irq_o[3])
    else $error("card irq not routed to line 3");

  AST_MGMT_SUPPRESS: assert property (
    igc_q[sspc_pkg::IGC_MGMT_SEL] && !card_irq && !ring_active
      |=> irq_o == 16'h0000)
    else $error("management irq not suppressed");

  AST_REG_CLEAR: assert property (
    $fell(sys_rst_i) |-> power_q == sspc_pkg::PWR_RST &&
                         igc_q == sspc_pkg::IGC_RST)
    else $error("control not cleared by reset");

  // Main scenario covers
  COV_INSERT_POWER: cover property (
    !present ##1 present ##[1:4] !vcc_3v3_n_o);
  COV_REMOVAL: cover property (removal ##1 !power_q[sspc_pkg::PWR_VCC]);
  COV_RING: cover property (ring_active ##1 irq_o[sspc_pkg::IRQ_RING_ALT]);

endmodule

// ===== logic/sspc_pkg.sv
// Purpose: Shared constants for the socket status, power and irq control.
// Assumes: One socket per instance; index/data register access.
// Notes:   Field positions and reset values used by the design; the bench repeats them as literals.
package sspc_pkg;

  // Register index space
  localparam int unsigned IDX_W           = 8;
  localparam logic [5:0]  REG_STATUS      = 6'h01;
  localparam logic [5:0]  REG_POWER       = 6'h02;
  localparam logic [5:0]  REG_IRQ_GEN     = 6'h03;
  localparam int unsigned IDX_SOCKET_BIT  = 6;
  localparam logic [7:0]  IDX_RST         = 8'h00;
  localparam logic [7:0]  IDX_WR_MASK     = 8'h7F;

  // Power control fields
  localparam int unsigned PWR_CARD_EN     = 7;
  localparam int unsigned PWR_AUTO        = 5;
  localparam int unsigned PWR_VCC         = 4;
  localparam int unsigned PWR_VPP_LO      = 0;
  localparam logic [7:0]  PWR_RST         = 8'h00;

  // Programming voltage field codes
  localparam logic [1:0]  VPP_FOLLOW_VCC  = 2'h1;
  localparam logic [1:0]  VPP_PROG_12V    = 2'h2;

  // Interrupt and general control fields
  localparam int unsigned IGC_RING_EN     = 7;
  localparam int unsigned IGC_RESET_OFF   = 6;
  localparam int unsigned IGC_IO_MODE     = 5;
  localparam int unsigned IGC_MGMT_SEL    = 4;
  localparam int unsigned IGC_LEVEL_LO    = 0;
  localparam logic [7:0]  IGC_RST         = 8'h00;

  // Status byte fields
  localparam int unsigned ST_TOP          = 7;
  localparam int unsigned ST_PWR_ON       = 6;

  // Interrupt routing
  localparam int unsigned IRQ_W           = 16;
  localparam logic [15:0] IRQ_VALID_MASK  = 16'hDEB8;
  localparam int unsigned IRQ_CLK_ALT     = 14;
  localparam int unsigned IRQ_RING_ALT    = 15;

  // Synchronised pin vector: {cd2_n, cd1_n, bvd2, bvd1, wp, ready}
  localparam int unsigned PIN_W           = 6;
  localparam int unsigned PIN_READY       = 0;
  localparam int unsigned PIN_WP          = 1;
  localparam int unsigned PIN_BVD1        = 2;
  localparam int unsigned PIN_BVD2        = 3;
  localparam int unsigned PIN_CD1_N       = 4;
  localparam int unsigned PIN_CD2_N       = 5;
  localparam logic [5:0]  PIN_RST         = 6'h30;

  // Read data for unmapped index
  localparam logic [7:0]  RD_NONE         = 8'h00;

endpackage

// ===== logic/sspc_sync.sv
// Purpose: Two flip-flop synchroniser for a bundle of card pin levels.
// Assumes: Synchronous active-high reset, single clock.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ps
module sspc_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         mclk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  // Elaboration check: an empty bundle cannot be synchronised
  if (W < 1) begin : g_bad_width
    $error("W must be at least 1");
  end

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Two stages, reset to the idle pin levels
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

// ===== dv/sspc_card_model.sv
// Purpose: Behavioural card seated in one socket.
// Assumes: Adapter side pulls every card pin up.
// Notes:   A card not fully seated leaves signal pins at the pull-up.
`timescale 1ns/1ps
module sspc_card_model (
  input  wire logic       seat1_i,
  input  wire logic       seat2_i,
  input  wire logic [3:0] lvl_i,
  output logic            cd1_n_o,
  output logic            cd2_n_o,
  output logic      [3:0] pin_o
);
  // Each detect contact grounds its pin once seated
  assign cd1_n_o = ~seat1_i;
  assign cd2_n_o = ~seat2_i;
  // Pins {bvd2, bvd1, wp, ready}; float to pull-up when unseated
  assign pin_o = (seat1_i & seat2_i) ? lvl_i : 4'hF;
endmodule

// ===== dv/socket_status_power_irq_ctrl_bench.sv
// Purpose: Self-checking bench for the socket control block.
// Assumes: Socket 0 instance; inputs change on the falling edge.
// Notes:   Expected values are worked out here from pin and reg state.
`timescale 1ns/1ps
module socket_status_power_irq_ctrl_bench;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        idx_wr = 1'b0;
  logic        data_wr = 1'b0;
  logic        data_rd = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic        rd_valid;
  logic        seat1 = 1'b1;
  logic        seat2 = 1'b1;
  logic [3:0]  lvl = 4'hF;
  logic        cd1_n;
  logic        cd2_n;
  logic [3:0]  pin;
  logic        sel3 = 1'b0;
  logic        aod = 1'b1;
  logic        lock = 1'b0;
  logic        ata = 1'b0;
  logic        rsel = 1'b0;
  logic        clksel = 1'b0;
  logic        mreq = 1'b0;
  logic [3:0]  mlvl = 4'h0;
  logic        v3n;
  logic        v5n;
  logic        prog;
  logic        follow;
  logic        oe;
  logic        crst;
  logic        crst_oe;
  logic        iom;
  logic [15:0] irq;
  logic [4:0]  pwr_vec;
  int          n_fail = 0;
  int          checks = 0;

  // Clock at 25 MHz
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end

  sspc_card_model i_card (
    .seat1_i (seat1),
    .seat2_i (seat2),
    .lvl_i   (lvl),
    .cd1_n_o (cd1_n),
    .cd2_n_o (cd2_n),
    .pin_o   (pin)
  );

  sspc_socket_ctrl #(.SOCKET_ID(0)) i_dut (
    .mclk_i                      (mclk_i),
    .sys_rst_i                   (sys_rst_i),
    .idx_wr_i                    (idx_wr),
    .data_wr_i                   (data_wr),
    .data_rd_i                   (data_rd),
    .wdata_i                     (wdata),
    .rdata_o                     (rdata),
    .rd_valid_o                  (rd_valid),
    .card_ready_irq_pin_i        (pin[0]),
    .write_protect_wide_io_pin_i (pin[1]),
    .card_detect_first_n_i       (cd1_n),
    .card_detect_second_n_i      (cd2_n),
    .battery_status_ring_pin_i   (pin[2]),
    .battery_warn_speaker_pin_i  (pin[3]),
    .vcc_3v3_sel_i               (sel3),
    .auto_off_disable_i          (aod),
    .vcc_write_lock_i            (lock),
    .ata_mode_i                  (ata),
    .irq15_ring_out_select_i     (rsel),
    .irq14_clk_in_sel_i          (clksel),
    .mgmt_irq_req_i              (mreq),
    .mgmt_irq_level_i            (mlvl),
    .vcc_3v3_n_o                 (v3n),
    .vcc_5v_n_o                  (v5n),
    .prog_voltage_select_o       (prog),
    .vpp_follow_vcc_o            (follow),
    .sock_out_en_o               (oe),
    .card_reset_o                (crst),
    .card_reset_oe_o             (crst_oe),
    .io_interface_mode_o         (iom),
    .irq_o                       (irq)
  );

  // Supply, programming and output enable levels as one word
  assign pwr_vec = {v3n, v5n, prog, follow, oe};

  // Counts and verdict, then end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compare one observed value with its expectation
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Index write, then data write
  task automatic wr(input logic [7:0] ix, input logic [7:0] dt);
    @(negedge mclk_i);
    idx_wr = 1'b1;
    wdata  = ix;
    @(negedge mclk_i);
    idx_wr  = 1'b0;
    data_wr = 1'b1;
    wdata   = dt;
    @(negedge mclk_i);
    data_wr = 1'b0;
  endtask

  // Index write, data read, bounded wait for the answer
  task automatic rd(input logic [7:0] ix, output logic [7:0] d);
    @(negedge mclk_i);
    idx_wr = 1'b1;
    wdata  = ix;
    @(negedge mclk_i);
    idx_wr  = 1'b0;
    data_rd = 1'b1;
    @(negedge mclk_i);
    data_rd = 1'b0;
    for (int k = 0; k < 3 && rd_valid !== 1'b1; k++) @(negedge mclk_i);
    if (rd_valid !== 1'b1) begin
      n_fail++;
      print_verdict();
    end else begin
      d = rdata;
    end
  endtask

  // Let pins pass the synchronisers and outputs register
  task automatic settle();
    repeat (5) @(negedge mclk_i);
  endtask

  // Status byte expected from seating and pin levels
  function automatic logic [7:0] exp_st(input logic io, input logic act);
    logic [3:0] p;
    p = (seat1 & seat2) ? lvl : 4'hF;
    return {1'b1, act, p[0], p[1], seat2, seat1, p[3] & ~io, p[2]};
  endfunction

  // Supplies, programming and output enable from a power byte
  function automatic logic [4:0] exp_pw(input logic [7:0] p);
    logic act;
    act = p[4] & (~p[5] | (seat1 & seat2));
    return {~(act & sel3), ~(act & ~sel3), act & (p[1:0] == 2'h2),
            act & (p[1:0] == 2'h1), seat1 & seat2 & p[7]};
  endfunction

  // One-hot line for a routing code; reserved codes route nowhere
  function automatic logic [15:0] exp_irq(input logic [3:0] c);
    return 16'hDEB8 & (16'h0001 << c);
  endfunction

  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    print_verdict();
  end

  initial begin
    logic [7:0] d;
    logic [7:0] p;
    logic [3:0] c;
    void'($urandom(49657));
    repeat (5) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    rd(8'h02, d);
    chk("power", 16'(d), 16'h0000);
    rd(8'h03, d);
    chk("igc", 16'(d), 16'h0000);
    chk("pwr_out", 16'({v3n, v5n, prog, follow, oe}), 16'h0018);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      {seat1, seat2, lvl} = (i < 3) ? {2'h3, 4'($urandom)} : 6'($urandom);
      settle();
      rd(8'h01, d);
      chk("status", 16'(d), 16'(exp_st(1'b0, 1'b0)));
    end
    $display("test status done");
    for (int i = 0; i < 12; i++) begin
      p = (8'($urandom) & 8'hB0) | 8'(i % 4);
      {seat1, seat2, sel3} = (i < 4) ? {2'h3, 1'($urandom)} : 3'($urandom);
      wr(8'h02, p);
      settle();
      chk("pwr_out", 16'(pwr_vec), 16'(exp_pw(p)));
      rd(8'h01, d);
      chk("pwr_on", 16'(d[6]), 16'(p[4] & (~p[5] | (seat1 & seat2))));
    end
    $display("test power done");
    {seat1, seat2, aod} = 3'h6;
    wr(8'h02, 8'h90);
    settle();
    {seat1, seat2} = 2'h0;
    settle();
    rd(8'h02, d);
    chk("removal", 16'(d), 16'h0080);
    {seat1, seat2, aod} = 3'h7;
    wr(8'h02, 8'h90);
    {seat1, seat2} = 2'h0;
    settle();
    rd(8'h02, d);
    chk("keep", 16'(d), 16'h0090);
    {seat1, seat2, lock} = 3'h7;
    wr(8'h02, 8'h20);
    rd(8'h02, d);
    chk("lock", 16'(d), 16'h0030);
    lock = 1'b0;
    $display("test removal done");
    lvl = 4'hE;
    for (int i = 0; i < 16; i++) begin
      wr(8'h03, 8'h60 | 8'(i));
      settle();
      chk("irq", irq, exp_irq(4'(i)));
      chk("io_mode", 16'(iom), 16'h0001);
    end
    clksel = 1'b1;
    wr(8'h03, 8'h6E);
    settle();
    chk("irq14_clk", irq, 16'h0000);
    clksel = 1'b0;
    wr(8'h03, 8'h43);
    settle();
    chk("irq_mem", irq, 16'h0000);
    lvl = 4'hF;
    for (int i = 0; i < 4; i++) begin
      c = 4'($urandom);
      mreq = 1'b1;
      mlvl = c;
      wr(8'h03, 8'h00);
      settle();
      chk("mgmt", irq, exp_irq(c));
      wr(8'h03, 8'h10);
      settle();
      chk("mgmt_off", irq, 16'h0000);
    end
    mreq = 1'b0;
    $display("test irq done");
    lvl = 4'hB;
    rsel = 1'b1;
    wr(8'h03, 8'hE0);
    settle();
    chk("ring", irq, 16'h8000);
    rd(8'h01, d);
    // Supply bit and auto-power still set with the card seated: power on
    chk("status_io", 16'(d), 16'(exp_st(1'b1, 1'b1)));
    rsel = 1'b0;
    settle();
    chk("ring_off", irq, 16'h0000);
    rsel = 1'b1;
    wr(8'h03, 8'hC0);
    settle();
    chk("ring_mem", irq, 16'h0000);
    rsel = 1'b0;
    $display("test ring done");
    wr(8'h02, 8'h80);
    for (int i = 0; i < 4; i++) begin
      ata = i[1];
      wr(8'h03, {1'b0, i[0], 6'h00});
      settle();
      chk("reset", 16'({crst_oe, crst}), 16'({1'b1, ~i[0] ^ i[1]}));
    end
    wr(8'h02, 8'h00);
    settle();
    chk("reset_oe", 16'({crst_oe, oe}), 16'h0000);
    $display("test reset pin done");
    wr(8'h42, 8'hB3);
    rd(8'h02, d);
    chk("other_sock", 16'(d), 16'h0000);
    rd(8'h42, d);
    chk("rd_sock_b", 16'(d), 16'h0000);
    rd(8'h05, d);
    chk("unmapped", 16'(d), 16'h0000);
    $display("test index done");
    print_verdict();
  end
endmodule
